// *** design/uart_mcls_defines.svh ***
/*
 * Constants for the modem-control and line-status block: register
 * offsets, field positions, reset values and receiver sampling counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef UART_MCLS_DEFINES_SVH
`define UART_MCLS_DEFINES_SVH

// register byte offsets
`define MCLS_MODEM_CTRL_OFF 8'h10
`define MCLS_LINE_STATUS_OFF 8'h14

// modem control fields
`define MCLS_DTR_BIT 0
`define MCLS_RTS_BIT 1
`define MCLS_LOOP_BIT 4
`define MCLS_AFC_BIT 5
`define MCLS_IR_BIT 6
`define MCLS_MODEM_CTRL_MASK 7'h73
`define MCLS_MODEM_CTRL_RST 7'h00

// line status fields
`define MCLS_READY_BIT 0
`define MCLS_OVERRUN_BIT 1
`define MCLS_PARITY_BIT 2
`define MCLS_FRAMING_BIT 3
`define MCLS_BREAK_BIT 4
`define MCLS_HOLD_EMPTY_BIT 5
`define MCLS_ALL_EMPTY_BIT 6
`define MCLS_QUEUE_ERR_BIT 7
`define MCLS_LINE_STATUS_RST 8'h60

// receiver samples per bit and mid-bit sample point
`define MCLS_SAMPLE_LAST 4'hF
`define MCLS_SAMPLE_MID 4'h7

`endif

// *** design/uart_mcls_pkg.sv ***
/*
 * Types for the modem-control and line-status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uart_mcls_pkg;

    // receiver sequencer, gray along idle-start-data-parity-stop
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP = 3'h6,
        RX_BRK_WAIT = 3'h7
    } rx_state_e;

    typedef logic [2:0] rx_err_t; // {break, framing, parity}

endpackage

// *** design/uart_modem_ctrl_line_status.sv ***
/*
 * Modem-control register, loopback/infrared routing, serial receiver
 * with receive queue, and line-status register of a 16550-style UART.
 * Assumes a 16x-baud sample_tick, line-control settings and transmitter
 * state supplied by neighbouring blocks, and synchronous pin inputs.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "uart_mcls_defines.svh"

// Functional notes
// - modem control bit 6 picks infrared mode, else plain UART; resets zero.
// - auto flow control works only with FIFOs enabled and bit 5 set.
// - loopback in UART mode holds serial out high, feeds tx to receiver.
// - loopback ignores modem-status pins, feeds control outputs back in.
// - loopback in infrared mode holds infrared out low, returns tx_serial uninverted.
// - interrupt-relevant status keeps working during loopback.
// - without auto flow, request pin is low when bit 1 set, else high.
// - with auto flow, request pin also goes high once the fill reaches the receive trigger.
// - loopback holds request and terminal pins high, loops bits inside.
// - terminal pin is inverse of bit 0.
// - queue error flag is zero without FIFOs, else any queued error.
// - all-empty flag is one when holding and shift stages are empty.
// - hold-empty flag is one when holding stage or TX FIFO is empty.
// - low line over a full character sets break, loads one zero character.
// - break shows at once without FIFO, at queue head with FIFO.
// - missing stop bit sets framing flag, at head in FIFO mode.
// - after framing error the low stop is taken as next start bit.
// - a break also sets framing and parity flags.
// - parity mismatch sets parity flag only with parity enabled.
// - without FIFO, unread buffer is overwritten and overrun set.
// - with full FIFO, new character is dropped and overrun set.
// - ready flag is one while a received character is waiting.
// - receive trigger also sets the auto flow request threshold.
// - in loopback, clear-to-send state equals request bit.
// - in loopback, set-ready state equals terminal-ready bit.
module uart_modem_ctrl_line_status
    import uart_mcls_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // settings from neighbouring registers, and the 16x sample tick
    input wire logic fifo_enable,
    input wire logic [1:0] rx_trigger,
    input wire logic [1:0] word_len,
    input wire logic parity_enable_bit,
    input wire logic even_parity,
    input wire logic sample_tick,
    // transmitter side
    input wire logic tx_serial,
    input wire logic ir_tx_pulse,
    input wire logic tx_hold_empty,
    input wire logic tx_shift_empty,
    input wire logic tx_write,
    // receive data port
    input wire logic rx_read,
    output logic [7:0] rx_buffer,
    output logic line_error_pending,
    // modem states toward the modem-status logic, active high
    output logic cts_state,
    output logic dsr_state,
    output logic ring_state,
    output logic dcd_state,
    // serial and modem pins
    input wire logic rx_pin,
    input wire logic ir_in_pin,
    output logic serial_out_pin,
    output logic ir_out_pin,
    output logic rts_pin_n,
    output logic dtr_pin_n,
    output logic aux_out_pin_a,
    output logic aux_out_pin_b,
    input wire logic cts_pin_n,
    input wire logic dsr_pin_n,
    input wire logic ring_pin,
    input wire logic dcd_pin_n
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // trigger level in entries for a given setting
    function automatic logic [AW:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = (AW+1)'(1);
            2'h1: trig_level = (AW+1)'(DEPTH / 4);
            2'h2: trig_level = (AW+1)'(DEPTH / 2);
            2'h3: trig_level = (AW+1)'(DEPTH - 2);
        endcase
    endfunction

    logic [6:0] mcr_q;
    logic [31:0] rdata_q;
    logic loop_on, ir_on, afc_on, over_thr;
    logic rx_bit;
    rx_state_e st_q;
    logic [3:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic par_q;
    logic [7:0] data_mem [DEPTH];
    rx_err_t err_mem [DEPTH];
    logic [AW-1:0] rd_ptr_q, wr_ptr_q;
    logic [AW:0] count_q;
    logic fifo_en_q, head_shown_q;
    logic overrun_q, parity_q, framing_q, break_q;
    logic push, pop, flush, overwrite, accept, full, reveal, lsr_read;
    logic [AW-1:0] wr_idx;
    rx_err_t push_err;
    logic stop_tick, par_err, queue_err;
    logic [7:0] line_status_reg;

    // mode decode
    assign loop_on = mcr_q[`MCLS_LOOP_BIT];
    assign ir_on = mcr_q[`MCLS_IR_BIT];
    assign afc_on = fifo_enable & mcr_q[`MCLS_AFC_BIT];
    assign over_thr = count_q >= trig_level(rx_trigger);

    // modem-control register, reserved bits never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mcr_q <= `MCLS_MODEM_CTRL_RST;
        end else if (reg_wr && reg_addr == `MCLS_MODEM_CTRL_OFF) begin
            mcr_q <= reg_wdata[6:0] & `MCLS_MODEM_CTRL_MASK;
        end
    end

    // modem output pins; loopback parks them inactive
    assign rts_pin_n = loop_on ? 1'b1 :
        ~(mcr_q[`MCLS_RTS_BIT] & ~(afc_on & over_thr));
    assign dtr_pin_n = loop_on ? 1'b1 : ~mcr_q[`MCLS_DTR_BIT];
    assign aux_out_pin_a = 1'b1;
    assign aux_out_pin_b = 1'b1;

    // modem inputs; loopback gives cts and dsr the control bits, ring and dcd zero
    assign cts_state = loop_on ? mcr_q[`MCLS_RTS_BIT] : ~cts_pin_n;
    assign dsr_state = loop_on ? mcr_q[`MCLS_DTR_BIT] : ~dsr_pin_n;
    assign ring_state = loop_on ? 1'b0 : ~ring_pin;
    assign dcd_state = loop_on ? 1'b0 : ~dcd_pin_n;

    // serial routing; infrared loop bypasses the pulse train and feeds tx_serial
    // straight to the receiver, as the UART loop does, so it sees tx_serial itself
    assign serial_out_pin = (loop_on & ~ir_on) ? 1'b1 : tx_serial;
    assign ir_out_pin = (loop_on & ir_on) ? 1'b0 : ir_tx_pulse;
    always_comb begin
        if (loop_on) begin
            rx_bit = tx_serial;
        end else if (ir_on) begin
            rx_bit = ~ir_in_pin;
        end else begin
            rx_bit = rx_pin;
        end
    end

    // stop-bit sample point and parity check
    assign stop_tick = st_q == RX_STOP && sample_tick
        && cnt_q == `MCLS_SAMPLE_LAST;
    assign par_err = parity_enable_bit & (^shift_q ^ par_q ^ ~even_parity);
    always_comb begin
        push_err = 3'h0;
        if (!rx_bit && shift_q == 8'h00 && !par_q) begin
            push_err = 3'h7;
        end else if (!rx_bit) begin
            push_err = {1'b0, 1'b1, par_err};
        end else begin
            push_err = {2'b00, par_err};
        end
    end
    assign push = stop_tick;

    // receiver sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= RX_IDLE;
            cnt_q <= 4'h0;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            par_q <= 1'b0;
        end else if (sample_tick) begin
            cnt_q <= cnt_q + 4'h1;
            unique case (st_q)
                RX_IDLE: begin
                    cnt_q <= 4'h0;
                    if (!rx_bit) begin
                        st_q <= RX_START;
                    end
                end
                RX_START: begin
                    // glitch filter: start must still be low at mid-bit
                    if (cnt_q == `MCLS_SAMPLE_MID) begin
                        cnt_q <= 4'h0;
                        bit_q <= 3'h0;
                        shift_q <= 8'h00;
                        par_q <= 1'b0;
                        st_q <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (cnt_q == `MCLS_SAMPLE_LAST) begin
                        shift_q[bit_q] <= rx_bit;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == {1'b1, word_len}) begin
                            st_q <= parity_enable_bit ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (cnt_q == `MCLS_SAMPLE_LAST) begin
                        par_q <= rx_bit;
                        st_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (cnt_q == `MCLS_SAMPLE_LAST) begin
                        bit_q <= 3'h0;
                        shift_q <= 8'h00;
                        par_q <= 1'b0;
                        if (push_err[2]) begin
                            st_q <= RX_BRK_WAIT;
                        end else if (!rx_bit) begin
                            st_q <= RX_DATA;
                        end else begin
                            st_q <= RX_IDLE;
                        end
                    end
                end
                RX_BRK_WAIT: begin
                    // one zero character per break, then wait for mark
                    if (rx_bit) begin
                        st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // queue control; non-FIFO mode behaves as a one-entry buffer
    assign flush = fifo_enable != fifo_en_q;
    assign pop = rx_read && count_q != '0;
    assign full = fifo_enable ? count_q == FULL_CNT : 1'b0;
    assign overwrite = !fifo_enable && count_q != '0 && !pop;
    assign accept = push && !full && !flush;
    assign wr_idx = overwrite ? rd_ptr_q : wr_ptr_q;

    // queue storage; popped entries lose their error marks
    always_ff @(posedge clk) begin
        if (accept) begin
            data_mem[wr_idx] <= shift_q;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                err_mem[i] <= 3'h0;
            end
        end else if (flush) begin
            for (int i = 0; i < DEPTH; i++) begin
                err_mem[i] <= 3'h0;
            end
        end else begin
            if (pop) begin
                err_mem[rd_ptr_q] <= 3'h0;
            end
            if (accept) begin
                err_mem[wr_idx] <= push_err;
            end
        end
    end

    // pointers, fill count and head-reveal tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            count_q <= '0;
            fifo_en_q <= 1'b0;
            head_shown_q <= 1'b0;
        end else begin
            fifo_en_q <= fifo_enable;
            if (flush) begin
                rd_ptr_q <= '0;
                wr_ptr_q <= '0;
                count_q <= '0;
                head_shown_q <= 1'b0;
            end else begin
                if (pop) begin
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                end
                if (accept && !overwrite) begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
                count_q <= count_q + (AW+1)'(accept && !overwrite)
                    - (AW+1)'(pop);
                if (pop) begin
                    head_shown_q <= 1'b0;
                end else if (reveal) begin
                    head_shown_q <= 1'b1;
                end
            end
        end
    end
    assign reveal = fifo_enable && count_q != '0 && !head_shown_q;

    // any error mark still queued
    always_comb begin
        queue_err = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            queue_err = queue_err | (|err_mem[i]);
        end
    end

    // sticky error flags: a set in the read cycle survives the clear
    assign lsr_read = reg_rd && reg_addr == `MCLS_LINE_STATUS_OFF;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_q <= 1'b0;
            parity_q <= 1'b0;
            framing_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            if (push && (full || overwrite)) begin
                overrun_q <= 1'b1;
            end else if (lsr_read) begin
                overrun_q <= 1'b0;
            end
            if (!fifo_enable && accept && push_err != 3'h0) begin
                // non-FIFO mode reports at once
                break_q <= break_q | push_err[2];
                framing_q <= framing_q | push_err[1];
                parity_q <= parity_q | push_err[0];
                if (lsr_read) begin
                    break_q <= push_err[2];
                    framing_q <= push_err[1];
                    parity_q <= push_err[0];
                end
            end else if (reveal && err_mem[rd_ptr_q] != 3'h0) begin
                // FIFO mode reports once the character is at the head
                break_q <= err_mem[rd_ptr_q][2] | (break_q & ~lsr_read);
                framing_q <= err_mem[rd_ptr_q][1] | (framing_q & ~lsr_read);
                parity_q <= err_mem[rd_ptr_q][0] | (parity_q & ~lsr_read);
            end else if (lsr_read) begin
                break_q <= 1'b0;
                framing_q <= 1'b0;
                parity_q <= 1'b0;
            end
        end
    end

    // status word assembled from live state
    always_comb begin
        line_status_reg = 8'h00;
        line_status_reg[`MCLS_READY_BIT] = count_q != '0;
        line_status_reg[`MCLS_OVERRUN_BIT] = overrun_q;
        line_status_reg[`MCLS_PARITY_BIT] = parity_q;
        line_status_reg[`MCLS_FRAMING_BIT] = framing_q;
        line_status_reg[`MCLS_BREAK_BIT] = break_q;
        line_status_reg[`MCLS_HOLD_EMPTY_BIT] = tx_hold_empty & ~tx_write;
        line_status_reg[`MCLS_ALL_EMPTY_BIT] = tx_hold_empty & tx_shift_empty
            & ~tx_write;
        line_status_reg[`MCLS_QUEUE_ERR_BIT] = fifo_enable & queue_err;
    end

    // loopback leaves the error report path untouched
    assign line_error_pending = |line_status_reg[4:1];

    // registered read data, one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `MCLS_MODEM_CTRL_OFF: rdata_q <= {25'h0, mcr_q};
                `MCLS_LINE_STATUS_OFF: rdata_q <= {24'h0, line_status_reg};
                default: rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end
    assign reg_rdata = rdata_q;
    assign rx_buffer = data_mem[rd_ptr_q];

    // checks on the outputs and flags
    sequence lsr_rd_s;
        lsr_read && !push && !reveal;
    endsequence
    sequence brk_push_s;
        push && push_err[2] && accept && !fifo_enable;
    endsequence

    loop_pins_high_a: assert property (
        @(posedge clk) disable iff (rst)
        loop_on |-> rts_pin_n && dtr_pin_n && serial_out_pin | ir_on)
        else $error("loopback did not park modem pins");
    dtr_inverse_a: assert property (
        @(posedge clk) disable iff (rst)
        !loop_on |-> dtr_pin_n == !mcr_q[`MCLS_DTR_BIT])
        else $error("terminal pin not inverse of its bit");
    rts_flow_a: assert property (
        @(posedge clk) disable iff (rst)
        !loop_on && afc_on && over_thr |-> rts_pin_n)
        else $error("request pin active above threshold");
    rts_plain_a: assert property (
        @(posedge clk) disable iff (rst)
        !loop_on && !afc_on |-> rts_pin_n == !mcr_q[`MCLS_RTS_BIT])
        else $error("request pin does not follow its bit");
    flags_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        lsr_rd_s |=> !framing_q && !parity_q && !break_q)
        else $error("status read left error flags set");
    break_all_a: assert property (
        @(posedge clk) disable iff (rst)
        brk_push_s |=> break_q && framing_q && parity_q)
        else $error("break did not set framing and parity");
    overrun_a: assert property (
        @(posedge clk) disable iff (rst)
        push && overwrite |=> overrun_q && count_q == $past(count_q))
        else $error("overwrite did not flag overrun");
    full_keep_a: assert property (
        @(posedge clk) disable iff (rst)
        push && full && !pop && !flush |=> overrun_q && count_q == FULL_CNT)
        else $error("full queue changed on new character");
    ready_rd_a: assert property (
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `MCLS_LINE_STATUS_OFF && count_q != '0
        ##1 !flush |-> reg_rdata[`MCLS_READY_BIT] || $past(pop))
        else $error("ready flag missing while data queued");
    queue_err_a: assert property (
        @(posedge clk) disable iff (rst)
        !fifo_enable |=> ##1 !reg_rdata[`MCLS_QUEUE_ERR_BIT] || fifo_en_q)
        else $error("queue error set without FIFOs");

endmodule

// *** verification/modem_model.sv ***
/*
 * Modem model on the serial side: sends framed characters, breaks and
 * resync tails on rx_pin, and drives the modem input lines.
 * Assumes sample_tick is the 16x baud pulse that the receiver uses.
 */
`timescale 1ns/1ps
module modem_model (
    // timing
    input wire logic clk,
    input wire logic sample_tick,
    // serial and modem lines toward the uart
    output logic rx_pin,
    output logic cts_pin_n,
    output logic dsr_pin_n,
    output logic ring_pin,
    output logic dcd_pin_n
);
    // idle line high, modem lines inactive high
    initial begin
        {rx_pin, cts_pin_n, dsr_pin_n, ring_pin, dcd_pin_n} = '1;
    end

    // one bit period is sixteen sample ticks
    task automatic bit_out(input logic v, input int n);
        rx_pin <= v;
        repeat (16 * n) @(posedge clk iff sample_tick);
    endtask

    // optional start, eight data bits lsb first, optional even parity, stop;
    // a low stop leaves the line low so the next call can skip its start
    task automatic send(input logic [7:0] d, input bit strt, input bit par,
            input bit par_bad, input bit stop_ok);
        int i;
        if (strt) bit_out(1'b0, 1);
        for (i = 0; i < 8; i++) bit_out(d[i], 1);
        if (par) bit_out(^d ^ par_bad, 1);
        bit_out(stop_ok, 1);
    endtask

    // line held low well past one character, then idle again
    task automatic brk;
        bit_out(1'b0, 14);
        bit_out(1'b1, 2);
    endtask

    // modem lines, active low
    task automatic set_lines(input logic [3:0] v);
        {cts_pin_n, dsr_pin_n, ring_pin, dcd_pin_n} <= v;
    endtask
endmodule

// *** verification/testbench.sv ***
/*
 * Self-checking bench for the modem-control and line-status block:
 * register tasks, modem model on the serial side, directed tests.
 * Assumes design files and package are compiled first.
 */
`timescale 1ns/1ps
`include "uart_mcls_defines.svh"
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    fails++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import uart_mcls_pkg::*;
    localparam int DEPTH = 8;
    localparam logic [7:0] MC = `MCLS_MODEM_CTRL_OFF;
    localparam logic [7:0] ST = `MCLS_LINE_STATUS_OFF;
    logic clk, rst, reg_wr, reg_rd, fifo_enable, parity_enable_bit;
    logic even_parity, tx_serial, ir_tx_pulse, tx_hold_empty;
    logic sample_tick = 1'b0;
    logic tx_shift_empty, tx_write, rx_read, line_error_pending, rx_pin;
    logic cts_state, dsr_state, ring_state, dcd_state, ir_in_pin;
    logic serial_out_pin, ir_out_pin, rts_pin_n, dtr_pin_n, aux_out_pin_a;
    logic aux_out_pin_b, cts_pin_n, dsr_pin_n, ring_pin, dcd_pin_n;
    logic [7:0] reg_addr, rx_buffer;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0] rx_trigger, word_len;
    int fails = 0;
    int cmp_count = 0;
    int lvl[4] = '{1, DEPTH / 4, DEPTH / 2, DEPTH - 2};

    uart_modem_ctrl_line_status #(.DEPTH(DEPTH)) dut_u (.clk, .rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fifo_enable,
        .rx_trigger, .word_len, .parity_enable_bit, .even_parity,
        .sample_tick, .tx_serial, .ir_tx_pulse, .tx_hold_empty,
        .tx_shift_empty, .tx_write, .rx_read, .rx_buffer,
        .line_error_pending, .cts_state, .dsr_state, .ring_state,
        .dcd_state, .rx_pin, .ir_in_pin, .serial_out_pin, .ir_out_pin,
        .rts_pin_n, .dtr_pin_n, .aux_out_pin_a, .aux_out_pin_b, .cts_pin_n,
        .dsr_pin_n, .ring_pin, .dcd_pin_n);

    modem_model modem_u (.clk, .sample_tick, .rx_pin, .cts_pin_n,
        .dsr_pin_n, .ring_pin, .dcd_pin_n);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // 16x tick every other cycle keeps frames short
    always @(posedge clk) sample_tick <= ~sample_tick;

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
            input string nm, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHECK(nm, ex, reg_rdata & m)
    endtask

    task automatic pop;
        @(posedge clk);
        rx_read <= 1'b1;
        @(posedge clk);
        rx_read <= 1'b0;
        #1;
    endtask

    // watchdog so a stuck receiver cannot hang the run
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        report_and_stop;
    end

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, fifo_enable, rx_trigger,
            parity_enable_bit, ir_tx_pulse, tx_write, rx_read,
            ir_in_pin} = '0;
        {rst, word_len, even_parity, tx_serial, tx_hold_empty,
            tx_shift_empty} = '1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(MC, 32'h0, "control reset");
        rd(ST, 32'h60, "status reset");
        rd(8'h20, 32'h0, "unmapped read");
        `CHECK("aux pins", 2'b11, {aux_out_pin_a, aux_out_pin_b})
        tx_shift_empty <= 1'b0;
        rd(ST, 32'h20, "shift not empty");
        tx_hold_empty <= 1'b0;
        rd(ST, 32'h00, "hold not empty");
        {tx_hold_empty, tx_shift_empty} <= 2'b11;
        @(posedge clk);
        {tx_write, reg_addr, reg_rd} <= {1'b1, ST, 1'b1};
        @(posedge clk);
        {tx_write, reg_rd} <= 2'b00;
        #1;
        `CHECK("write drops empty", 32'h0, reg_rdata)
        $display("test tx flags done");
        // control register and modem pins
        modem_u.set_lines(4'h0);
        ir_tx_pulse <= 1'b1;
        wr(MC, 32'hFFFF_FFFF);
        rd(MC, 32'h73, "reserved bits");
        `CHECK("loop pins", 2'b11, {rts_pin_n, dtr_pin_n})
        `CHECK("loop states", 4'hC, {cts_state, dsr_state, ring_state,
            dcd_state})
        `CHECK("ir loop out", 1'b0, ir_out_pin)
        wr(MC, 32'h10);
        tx_serial <= 1'b0;
        @(posedge clk);
        #1;
        `CHECK("loop serial out", 1'b1, serial_out_pin)
        `CHECK("loop ignores pins", 4'h0, {cts_state, dsr_state, ring_state,
            dcd_state})
        tx_serial <= 1'b1;
        wr(MC, 32'h40);
        `CHECK("ir out", 1'b1, ir_out_pin)
        wr(MC, 32'h03);
        `CHECK("pins asserted", 2'b00, {rts_pin_n, dtr_pin_n})
        `CHECK("pin states", 4'hF, {cts_state, dsr_state, ring_state,
            dcd_state})
        wr(MC, 32'h01);
        `CHECK("rts released", 2'b10, {rts_pin_n, dtr_pin_n})
        $display("test modem control done");
        // receiver without fifo; auto flow must stay off
        wr(MC, 32'h22);
        modem_u.send(8'hA5, 1, 0, 0, 1);
        rd(ST, 32'h61, "ready");
        `CHECK("first char", 8'hA5, rx_buffer)
        `CHECK("no auto flow", 1'b0, rts_pin_n)
        modem_u.send(8'h5A, 1, 0, 0, 1);
        rd(ST, 32'h63, "overrun");
        `CHECK("overwritten", 8'h5A, rx_buffer)
        rd(ST, 32'h61, "overrun cleared");
        pop;
        rd(ST, 32'h60, "ready cleared");
        parity_enable_bit <= 1'b1;
        modem_u.send(8'h33, 1, 1, 1, 1);
        rd(ST, 32'h65, "parity error");
        pop;
        modem_u.send(8'h34, 1, 1, 0, 1);
        rd(ST, 32'h61, "parity good");
        pop;
        even_parity <= 1'b0;
        modem_u.send(8'h35, 1, 1, 1, 1);
        rd(ST, 32'h61, "odd parity good");
        pop;
        even_parity <= 1'b1;
        parity_enable_bit <= 1'b0;
        modem_u.brk;
        `CHECK("error pending", 1'b1, line_error_pending)
        rd(ST, 32'h7D, "break");
        `CHECK("break char", 8'h00, rx_buffer)
        rd(ST, 32'h61, "break cleared");
        `CHECK("error gone", 1'b0, line_error_pending)
        pop;
        rd(ST, 32'h60, "one break char");
        // looped-back break must still raise the error report
        wr(MC, 32'h10);
        tx_serial <= 1'b0;
        repeat (400) @(posedge clk);
        tx_serial <= 1'b1;
        repeat (40) @(posedge clk);
        `CHECK("loop error", 1'b1, line_error_pending)
        rd(ST, 32'h7D, "loop break");
        pop;
        $display("test plain receive done");
        // fifo mode: errors revealed at head, resync after framing
        fifo_enable <= 1'b1;
        wr(MC, 32'h0);
        modem_u.send(8'h11, 1, 0, 0, 1);
        modem_u.send(8'h22, 1, 0, 0, 0);
        modem_u.send(8'h3C, 0, 0, 0, 1);
        rd(ST, 32'hE1, "queued error");
        `CHECK("head good", 8'h11, rx_buffer)
        pop;
        rd(ST, 32'hE9, "framing at head");
        `CHECK("framed char", 8'h22, rx_buffer)
        pop;
        rd(ST, 32'h61, "after framing", 32'h7F);
        `CHECK("resync char", 8'h3C, rx_buffer)
        pop;
        rd(ST, 32'h60, "queue empty");
        $display("test fifo errors done");
        // fill with auto flow, every trigger code, then overrun
        wr(MC, 32'h22);
        `CHECK("flow open", 1'b0, rts_pin_n)
        for (int i = 0; i < 9; i++) begin
            modem_u.send(8'h80 + i[7:0], 1, 0, 0, 1);
            for (int t = 0; t < 4 && i < 8; t++) begin
                rx_trigger <= t[1:0];
                repeat (2) @(posedge clk);
                #1;
                `CHECK("flow gate", (i + 1 >= lvl[t]), rts_pin_n)
            end
        end
        rd(ST, 32'h63, "fifo overrun");
        for (int i = 0; i < 8; i++) begin
            `CHECK("kept char", 8'h80 + i[7:0], rx_buffer)
            pop;
        end
        rd(ST, 32'h60, "drained");
        `CHECK("flow reopened", 1'b0, rts_pin_n)
        $display("test fifo fill done");
        report_and_stop;
    end
endmodule
